// file: rtl/szq_defs.svh
// Offsets, field positions and reset values for the
// calibration/class-of-service configuration slice.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef SZQ_DEFS_SVH
`define SZQ_DEFS_SVH

// Register byte offsets
`define SZQ_OFF_IRQ_SET     12'h000
`define SZQ_OFF_IRQ_CLR     12'h004
`define SZQ_OFF_CAL_CFG     12'h008
`define SZQ_OFF_PRIO_MAP    12'h00C
`define SZQ_OFF_MST1_MAP    12'h010
`define SZQ_OFF_CAL_STATUS  12'h014

// Interrupt enable bit positions
`define SZQ_IRQ_SBE_BIT     5
`define SZQ_IRQ_DBE_BIT     4
`define SZQ_IRQ_WRE_BIT     3
`define SZQ_IRQ_CAE_BIT     0
`define SZQ_IRQ_MASK        32'h0000_0039

// Calibration configuration fields
`define SZQ_CAL_RANK1_BIT   31
`define SZQ_CAL_RANK0_BIT   30
`define SZQ_CAL_DUAL_BIT    29
`define SZQ_CAL_EXIT_BIT    28
`define SZQ_CAL_MULT_HI     18
`define SZQ_CAL_MULT_LO     16
`define SZQ_CAL_INTV_HI     15
`define SZQ_CAL_INTV_LO     0
`define SZQ_CAL_MASK        32'hF007_FFFF

// Priority map fields
`define SZQ_PRIO_EN_BIT     31
`define SZQ_PRIO_MASK       32'h8000_FFFF

// Master-ID class-1 map fields
`define SZQ_MST_EN_BIT      31
`define SZQ_MST_A_HI        30
`define SZQ_MST_A_LO        23
`define SZQ_MSK_A_HI        22
`define SZQ_MSK_A_LO        20
`define SZQ_MST_B_HI        19
`define SZQ_MST_B_LO        12
`define SZQ_MSK_B_HI        11
`define SZQ_MSK_B_LO        10
`define SZQ_MST_C_HI        9
`define SZQ_MST_C_LO        2
`define SZQ_MSK_C_HI        1
`define SZQ_MSK_C_LO        0

// Reset values
`define SZQ_RST_ZERO        32'h0000_0000

`endif

// file: rtl/szq_pkg.sv
// Types shared by the configuration slice.
// Assumes nothing beyond SystemVerilog.
package szq_pkg;

  // Class of service a command ends in
  typedef enum logic [1:0]
  {
    SZQ_COS_NONE = 2'b00,
    SZQ_COS_1    = 2'b01,
    SZQ_COS_2    = 2'b10
  } szq_cos_t;

  // Calibration command kind sent to the SDRAM
  typedef enum logic [1:0]
  {
    SZQ_CAL_IDLE  = 2'b00,
    SZQ_CAL_SHORT = 2'b01,
    SZQ_CAL_LONG  = 2'b10
  } szq_cal_t;

  // Scheduler states
  typedef enum logic [1:0]
  {
    SZQ_ST_WAIT  = 2'b00,
    SZQ_ST_RANK0 = 2'b01,
    SZQ_ST_RANK1 = 2'b10
  } szq_state_t;

endpackage

// file: rtl/szq_mst_match.sv
// One masked master-ID comparator for the class-1 map.
// Assumes the ID and settings come from the same clock domain.
`timescale 1ns/1ps
module szq_mst_match #(
  parameter int ID_W = 8
) (
  // Command identity
  input  wire logic [ID_W-1:0] masterId,
  // Compare value and mask code
  input  wire logic [ID_W-1:0] compareVal,
  input  wire logic [2:0]      maskCode,
  // Result
  output logic                 hit
);
  import szq_pkg::*;

  // Mask codes drop up to three low bits
  if (ID_W < 3)
  begin
    $error("szq_mst_match: ID_W must be at least 3");
  end

  logic [ID_W-1:0] careBits;

  // Codes 1..3 drop low ID bits; code 0 and unused codes compare all
  always_comb
  begin
    careBits = '1;
    case (maskCode)
      3'h1: careBits[0] = 1'b0;
      3'h2: careBits[1:0] = 2'h0;
      3'h3: careBits[2:0] = 3'h0;
      default: careBits = '1;
    endcase
  end

  assign hit = ((masterId ^ compareVal) & careBits) == '0;
endmodule

// file: rtl/szq_config_regs.sv
// Configuration slice: interrupt enables, impedance calibration scheduler,
// priority and master-ID class-of-service mapping, APB slave.
// Assumes refresh ticks and power-state exits come from the same clock.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "szq_defs.svh"
module szq_config_regs #(
  parameter int ID_W = 8,
  parameter int PRIO_W = 3
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Interrupt sources and enabled output
  input  wire logic [5:0]            irqRaw,
  output logic [5:0]                 irqEnabled,
  // Calibration scheduler inputs
  input  wire logic                  refreshTick,
  input  wire logic                  powerExit,
  input  wire logic                  calAck,
  // Calibration command to the SDRAM sequencer
  output szq_pkg::szq_cal_t          calCmd,
  output logic [1:0]                 calRanks,
  // Command classification
  input  wire logic [PRIO_W-1:0]     cmdPrio,
  input  wire logic [ID_W-1:0]       cmdMasterId,
  output szq_pkg::szq_cos_t          cmdCos
);
  import szq_pkg::*;

  // Named copy of the enable mask so its low bits can be sliced
  localparam logic [31:0] IRQ_MASK = `SZQ_IRQ_MASK;

  // Field layout is fixed by the register map
  if (ID_W != 8 || PRIO_W != 3)
  begin
    $error("szq_config_regs: ID_W must be 8 and PRIO_W 3");
  end

  logic [5:0]  irqEn_q;
  logic [31:0] calCfg_q;
  logic [31:0] prioMap_q;
  logic [31:0] mstMap_q;
  logic        wrAccess;
  logic        exitPend_q;
  logic        exitHit;
  logic [15:0] refCnt_q;
  logic [2:0]  shortCnt_q;
  logic        duePend_q;
  logic        dueLong_q;
  szq_state_t  state_q;
  szq_cal_t    curKind_q;
  logic [2:0]  mstHit;
  logic [1:0]  prioField;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wrAccess = psel && penable && pwrite;

  // Unmapped offsets answer with an error
  always_comb
  begin
    case (paddr)
      `SZQ_OFF_IRQ_SET, `SZQ_OFF_IRQ_CLR, `SZQ_OFF_CAL_CFG,
      `SZQ_OFF_PRIO_MAP, `SZQ_OFF_MST1_MAP, `SZQ_OFF_CAL_STATUS:
        pslverr = 1'b0;
      default:
        pslverr = psel && penable;
    endcase
  end

  // Interrupt enables: both views share one store, so they cannot disagree
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irqEn_q <= 6'h00;
    else if (wrAccess && paddr == `SZQ_OFF_IRQ_SET)
      irqEn_q <= irqEn_q | (pwdata[5:0] & IRQ_MASK[5:0]);
    else if (wrAccess && paddr == `SZQ_OFF_IRQ_CLR)
      irqEn_q <= irqEn_q & ~(pwdata[5:0] & IRQ_MASK[5:0]);
  end

  // Enabled view of the raw sources
  assign irqEnabled = irqRaw & irqEn_q;

  // Calibration configuration; reserved bits never stored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      calCfg_q <= `SZQ_RST_ZERO;
    else if (wrAccess && paddr == `SZQ_OFF_CAL_CFG)
      calCfg_q <= pwdata & `SZQ_CAL_MASK;
  end

  // Priority map; reserved bits never stored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prioMap_q <= `SZQ_RST_ZERO;
    else if (wrAccess && paddr == `SZQ_OFF_PRIO_MAP)
      prioMap_q <= pwdata & `SZQ_PRIO_MASK;
  end

  // Master-ID class-1 map, all fields writable
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mstMap_q <= `SZQ_RST_ZERO;
    else if (wrAccess && paddr == `SZQ_OFF_MST1_MAP)
      mstMap_q <= pwdata;
  end

  // Read mux, registered so data comes from flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `SZQ_OFF_IRQ_SET, `SZQ_OFF_IRQ_CLR:
          prdata <= {26'h0000000, irqEn_q};
        `SZQ_OFF_CAL_CFG:    prdata <= calCfg_q;
        `SZQ_OFF_PRIO_MAP:   prdata <= prioMap_q;
        `SZQ_OFF_MST1_MAP:   prdata <= mstMap_q;
        `SZQ_OFF_CAL_STATUS: prdata <= {22'h000000, shortCnt_q, exitPend_q, duePend_q,
                                        dueLong_q, state_q, curKind_q};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Exit request waits until WAIT takes it, then clears even with no rank enabled; a new exit wins over the issue-clear
  assign exitHit = powerExit && calCfg_q[`SZQ_CAL_EXIT_BIT];
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      exitPend_q <= 1'b0;
    else if (exitHit)
      exitPend_q <= 1'b1;
    else if (state_q == SZQ_ST_WAIT && exitPend_q)
      exitPend_q <= 1'b0;
  end

  // Refresh-period count; short calibration due after interval+1 ticks
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      refCnt_q   <= 16'h0000;
      shortCnt_q <= 3'h0;
      duePend_q  <= 1'b0;
      dueLong_q  <= 1'b0;
    end
    else
    begin
      if (refreshTick)
      begin
        if (refCnt_q >= calCfg_q[`SZQ_CAL_INTV_HI:`SZQ_CAL_INTV_LO])
        begin
          refCnt_q  <= 16'h0000;
          duePend_q <= 1'b1;
          // Every (multiplier+1)th interval turns long; counter restarts from zero
          if (shortCnt_q >= calCfg_q[`SZQ_CAL_MULT_HI:`SZQ_CAL_MULT_LO])
          begin
            shortCnt_q <= 3'h0;
            dueLong_q  <= 1'b1;
          end
          else
            shortCnt_q <= shortCnt_q + 3'h1;
        end
        else
          refCnt_q <= refCnt_q + 16'h0001;
      end
      if (state_q == SZQ_ST_WAIT && !exitPend_q && duePend_q && !refreshTick)
      begin
        duePend_q <= 1'b0;
        dueLong_q <= 1'b0;
      end
    end
  end

  // Issue state machine: one rank at a time unless dual calibration
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q   <= SZQ_ST_WAIT;
      curKind_q <= SZQ_CAL_IDLE;
    end
    else
    begin
      case (state_q)
        SZQ_ST_WAIT:
        begin
          if (exitPend_q || (duePend_q && !refreshTick))
          begin
            curKind_q <= (exitPend_q || dueLong_q) ? SZQ_CAL_LONG : SZQ_CAL_SHORT;
            if (calCfg_q[`SZQ_CAL_RANK0_BIT])
              state_q <= SZQ_ST_RANK0;
            else if (calCfg_q[`SZQ_CAL_RANK1_BIT])
              state_q <= SZQ_ST_RANK1;
          end
        end
        SZQ_ST_RANK0:
        begin
          if (calAck)
          begin
            if (calCfg_q[`SZQ_CAL_RANK1_BIT] && !calCfg_q[`SZQ_CAL_DUAL_BIT])
              state_q <= SZQ_ST_RANK1;
            else
              state_q <= SZQ_ST_WAIT;
          end
        end
        SZQ_ST_RANK1:
        begin
          if (calAck)
            state_q <= SZQ_ST_WAIT;
        end
        default:
          state_q <= SZQ_ST_WAIT;
      endcase
    end
  end

  // Command outputs held until acknowledged
  always_comb
  begin
    calCmd   = SZQ_CAL_IDLE;
    calRanks = 2'b00;
    case (state_q)
      SZQ_ST_RANK0:
      begin
        calCmd      = curKind_q;
        calRanks[0] = 1'b1;
        calRanks[1] = calCfg_q[`SZQ_CAL_DUAL_BIT] && calCfg_q[`SZQ_CAL_RANK1_BIT];
      end
      SZQ_ST_RANK1:
      begin
        calCmd   = curKind_q;
        calRanks = 2'b10;
      end
      default:
      begin
        calCmd   = SZQ_CAL_IDLE;
        calRanks = 2'b00;
      end
    endcase
  end

  // Three masked master-ID comparators
  szq_mst_match #(.ID_W(ID_W)) u_match_a (
    .masterId   (cmdMasterId),
    .compareVal (mstMap_q[`SZQ_MST_A_HI:`SZQ_MST_A_LO]),
    .maskCode   (mstMap_q[`SZQ_MSK_A_HI:`SZQ_MSK_A_LO]),
    .hit        (mstHit[0])
  );
  szq_mst_match #(.ID_W(ID_W)) u_match_b (
    .masterId   (cmdMasterId),
    .compareVal (mstMap_q[`SZQ_MST_B_HI:`SZQ_MST_B_LO]),
    .maskCode   ({1'b0, mstMap_q[`SZQ_MSK_B_HI:`SZQ_MSK_B_LO]}),
    .hit        (mstHit[1])
  );
  szq_mst_match #(.ID_W(ID_W)) u_match_c (
    .masterId   (cmdMasterId),
    .compareVal (mstMap_q[`SZQ_MST_C_HI:`SZQ_MST_C_LO]),
    .maskCode   ({1'b0, mstMap_q[`SZQ_MSK_C_HI:`SZQ_MSK_C_LO]}),
    .hit        (mstHit[2])
  );

  // Priority field select, priority 0 in the low bits
  assign prioField = prioMap_q[{cmdPrio, 1'b0} +: 2];

  // Class decision: master-ID match takes precedence over priority map
  always_comb
  begin
    cmdCos = SZQ_COS_NONE;
    if (mstMap_q[`SZQ_MST_EN_BIT] && (|mstHit))
      cmdCos = SZQ_COS_1;
    else if (prioMap_q[`SZQ_PRIO_EN_BIT])
    begin
      case (prioField)
        2'h1:    cmdCos = SZQ_COS_1;
        2'h2:    cmdCos = SZQ_COS_2;
        default: cmdCos = SZQ_COS_NONE;
      endcase
    end
  end
endmodule

// file: bench/szq_config_regs_monitor.sv
// Port checker for the configuration slice.
// Assumes it is bound onto szq_config_regs and sees its ports only.
`timescale 1ns/1ps
module szq_config_regs_monitor #(
  parameter int ID_W   = 8,
  parameter int PRIO_W = 3
) (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // APB side
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  // Interrupts
  input wire logic [5:0]         irqRaw,
  input wire logic [5:0]         irqEnabled,
  // Calibration
  input wire logic               refreshTick,
  input wire logic               powerExit,
  input wire logic               calAck,
  input wire szq_pkg::szq_cal_t  calCmd,
  input wire logic [1:0]         calRanks,
  // Classification
  input wire logic [PRIO_W-1:0]  cmdPrio,
  input wire logic [ID_W-1:0]    cmdMasterId,
  input wire szq_pkg::szq_cos_t  cmdCos
);
  import szq_pkg::*;

  // One domain, so clock and reset are given once
  default clocking mcb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("unmapped access not refused");
  a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 12'h014 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (psel && penable && !pwrite && paddr == 12'h008
    |-> prdata[27:19] == 9'h000)
    else $error("reserved calibration bits read nonzero");
  a_clear_drops: assert property (psel && penable && pwrite && paddr == 12'h004
    |=> (irqEnabled & $past(pwdata[5:0]) & 6'h39) == 6'h00)
    else $error("enable survived a clear write");
  a_set_raises: assert property (psel && penable && pwrite && paddr == 12'h000 && pwdata[0] && irqRaw[0]
    |=> irqEnabled[0])
    else $error("set write did not enable");
  a_reset_quiet: assert property ($fell(rst) |-> calCmd == SZQ_CAL_IDLE && irqEnabled == 6'h00
    && cmdCos == SZQ_COS_NONE)
    else $error("outputs not quiet after reset");
  a_cal_holds: assert property (calCmd != SZQ_CAL_IDLE && !calAck |=> $stable(calCmd) && $stable(calRanks))
    else $error("command moved before acceptance");
  a_cal_ranks: assert property (calCmd != SZQ_CAL_IDLE |-> calRanks != 2'b00)
    else $error("command with no rank");
endmodule

bind szq_config_regs szq_config_regs_monitor #(.ID_W(ID_W), .PRIO_W(PRIO_W)) mon (.ref_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irqRaw, .irqEnabled, .refreshTick,
  .powerExit, .calAck, .calCmd, .calRanks, .cmdPrio, .cmdMasterId, .cmdCos);

// file: bench/szq_cal_seq_model.sv
// Stand-in for the SDRAM sequencer that accepts calibration commands.
// Assumes calCmd stays up until the one-cycle calAck is seen.
`timescale 1ns/1ps
module szq_cal_seq_model (
  // Clock, reset and pace
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               slowAck,
  // Command in, acceptance out
  input  wire szq_pkg::szq_cal_t  calCmd,
  output logic                    calAck
);
  import szq_pkg::*;
  logic [3:0] waitCnt_q;

  // Accept at once or after five cycles; slow pace stresses the hold
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      waitCnt_q <= 4'h0;
      calAck    <= 1'b0;
    end
    else
    begin
      calAck <= 1'b0;
      if (calCmd != SZQ_CAL_IDLE && !calAck)
      begin
        waitCnt_q <= waitCnt_q + 4'h1;
        if (waitCnt_q >= (slowAck ? 4'h5 : 4'h0))
        begin
          calAck    <= 1'b1;
          waitCnt_q <= 4'h0;
        end
      end
    end
  end
endmodule

// file: bench/szq_tb.sv
// Self-checking bench for the configuration slice.
// Assumes rtl/ on the include path and the sequencer model alongside.
`timescale 1ns/1ps
`include "szq_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  import szq_pkg::*;
  // Counters and design pins
  int          checked = 0;
  int          mismatches = 0;
  int          bitPos [4] = '{5, 4, 3, 0};
  logic [15:0] idTab [6] = '{16'h4701, 16'h4800, 16'h1201, 16'h1300, 16'h8001, 16'h8200};
  logic [31:0] en;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [5:0]  irqRaw = 6'h3F, irqEnabled;
  logic        refreshTick = 1'b0, powerExit = 1'b0, calAck, slowAck = 1'b1;
  logic [1:0]  calRanks;
  logic [2:0]  cmdPrio = 3'h0;
  logic [7:0]  cmdMasterId = 8'h00;
  szq_cal_t    calCmd;
  szq_cos_t    cmdCos;

  szq_config_regs uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .irqRaw, .irqEnabled, .refreshTick, .powerExit, .calAck, .calCmd, .calRanks, .cmdPrio,
    .cmdMasterId, .cmdCos);
  szq_cal_seq_model seq (.ref_clk, .rst, .slowAck, .calCmd, .calAck);

  // 50 MHz clock
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Setup then access; waits for pready rather than assuming zero waits
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, r);
    `CHK("prdata", e, r)
  endtask

  // One-cycle refresh tick or power-state exit
  task automatic pulse(input bit ex);
    @(posedge ref_clk);
    refreshTick <= !ex;
    powerExit <= ex;
    @(posedge ref_clk);
    refreshTick <= 1'b0;
    powerExit <= 1'b0;
    @(negedge ref_clk);
  endtask

  // Bounded wait for a command, compare, then wait out its acceptance
  task automatic cal_chk(input szq_cal_t k, input logic [1:0] rk);
    int n;
    n = 0;
    while (calCmd === SZQ_CAL_IDLE && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("calCmd", k, calCmd)
    `CHK("calRanks", rk, calRanks)
    while (calAck !== 1'b1 && n < 80)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cuts a hang short well past the expected few hundred cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SZQ_OFF_IRQ_CLR, 32'h0);
    rd(`SZQ_OFF_PRIO_MAP, 32'h0);
    rd(`SZQ_OFF_MST1_MAP, 32'h0);
    $display("test reset done");
    wr(`SZQ_OFF_IRQ_SET, 32'hFFFF_FFFF);
    rd(`SZQ_OFF_IRQ_CLR, 32'h0000_0039);
    `CHK("irqEnabled", 6'h39, irqEnabled)
    wr(`SZQ_OFF_IRQ_CLR, 32'h0);
    rd(`SZQ_OFF_IRQ_SET, 32'h0000_0039);
    en = 32'h39;
    for (int i = 0; i < 4; i++)
    begin
      en &= ~(32'h1 << bitPos[i]);
      wr(`SZQ_OFF_IRQ_CLR, 32'h1 << bitPos[i]);
      rd(`SZQ_OFF_IRQ_SET, en);
      `CHK("irqEnabled", en[5:0], irqEnabled)
    end
    $display("test irq done");
    wr(`SZQ_OFF_CAL_CFG, 32'hFFFF_FFFF);
    rd(`SZQ_OFF_CAL_CFG, 32'hF007_FFFF);
    wr(`SZQ_OFF_PRIO_MAP, 32'hFFFF_FFFF);
    rd(`SZQ_OFF_PRIO_MAP, 32'h8000_FFFF);
    wr(`SZQ_OFF_MST1_MAP, 32'hFFFF_FFFF);
    rd(`SZQ_OFF_MST1_MAP, 32'hFFFF_FFFF);
    wr(12'h020, 32'hFFFF_FFFF);
    rd(12'h020, 32'h0);
    $display("test fields done");
    // Priority p gets field value p mod 4
    wr(`SZQ_OFF_MST1_MAP, 32'h0);
    wr(`SZQ_OFF_PRIO_MAP, 32'h8000_E4E4);
    for (int p = 0; p < 8; p++)
    begin
      @(posedge ref_clk);
      cmdPrio <= p[2:0];
      @(negedge ref_clk);
      `CHK("cmdCos", (p % 4 == 1 || p % 4 == 2) ? p[1:0] : 2'b00, cmdCos)
    end
    wr(`SZQ_OFF_PRIO_MAP, 32'h0000_E4E4);
    @(posedge ref_clk);
    cmdPrio <= 3'h1;
    @(negedge ref_clk);
    `CHK("cmdCos", 2'b00, cmdCos)
    // Values 40/mask3, 12/mask0, 81/mask1; table holds id and class
    wr(`SZQ_OFF_MST1_MAP, 32'hA031_2205);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      cmdMasterId <= idTab[i][15:8];
      @(negedge ref_clk);
      `CHK("cmdCos", idTab[i][1:0], cmdCos)
    end
    wr(`SZQ_OFF_MST1_MAP, 32'h2031_2205);
    @(posedge ref_clk);
    cmdMasterId <= 8'h47;
    @(negedge ref_clk);
    `CHK("cmdCos", 2'b00, cmdCos)
    $display("test class done");
    wr(`SZQ_OFF_CAL_CFG, 32'h4001_0001);
    pulse(1'b0);
    repeat (6) @(negedge ref_clk);
    `CHK("calCmd", SZQ_CAL_IDLE, calCmd)
    pulse(1'b0);
    cal_chk(SZQ_CAL_SHORT, 2'b01);
    pulse(1'b0);
    pulse(1'b0);
    cal_chk(SZQ_CAL_LONG, 2'b01);
    @(posedge ref_clk);
    slowAck <= 1'b0;
    wr(`SZQ_OFF_CAL_CFG, 32'hD000_FFFF);
    pulse(1'b1);
    cal_chk(SZQ_CAL_LONG, 2'b01);
    cal_chk(SZQ_CAL_LONG, 2'b10);
    wr(`SZQ_OFF_CAL_CFG, 32'hF000_FFFF);
    pulse(1'b1);
    cal_chk(SZQ_CAL_LONG, 2'b11);
    wr(`SZQ_OFF_CAL_CFG, 32'h9000_FFFF);
    pulse(1'b1);
    cal_chk(SZQ_CAL_LONG, 2'b10);
    wr(`SZQ_OFF_CAL_CFG, 32'hC000_FFFF);
    pulse(1'b1);
    repeat (6) @(negedge ref_clk);
    `CHK("calCmd", SZQ_CAL_IDLE, calCmd)
    $display("test cal done");
    give_verdict();
  end
endmodule
